// ---- src/dpc_pkg.sv ----
// Package for the digipot command and control block: command codes, field
// positions, memory map, reset values and timing counts.
// Assumes a 20 MHz core clock and a 16-bit serial frame from the host.
package dpc_pkg;

  // ---------------------------------------------------------------------------
  // Frame layout
  // ---------------------------------------------------------------------------
  localparam int         FRAME_BITS   = 16;
  localparam int         CMD_MSB      = 13;
  localparam int         CMD_LSB      = 10;
  localparam int         DATA_BITS    = 10;
  localparam int         ADDR_BITS    = 5;

  // ---------------------------------------------------------------------------
  // Command codes
  // ---------------------------------------------------------------------------
  localparam logic [3:0] CMD_NOP      = 4'h0;
  localparam logic [3:0] CMD_WR_WIPER = 4'h1;
  localparam logic [3:0] CMD_RD_WIPER = 4'h2;
  localparam logic [3:0] CMD_STORE    = 4'h3;
  localparam logic [3:0] CMD_REFRESH  = 4'h4;
  localparam logic [3:0] CMD_RD_MEM   = 4'h5;
  localparam logic [3:0] CMD_WR_CTRL  = 4'h6;
  localparam logic [3:0] CMD_RD_CTRL  = 4'h7;
  localparam logic [3:0] CMD_SHUTDOWN = 4'h8;

  // ---------------------------------------------------------------------------
  // Control bits and memory map
  // ---------------------------------------------------------------------------
  localparam int         CTL_PROG_EN  = 0;
  localparam int         CTL_UNLOCK   = 1;
  localparam int         CTL_CAL_SEL  = 2;
  localparam int         CTL_PROG_OK  = 3;
  localparam logic [3:0] CTL_RESET    = 4'h0;
  localparam int         MEM_ENTRIES  = 20;
  localparam logic [4:0] ADDR_FILL_LO = 5'h14;
  localparam logic [4:0] ADDR_FILL_HI = 5'h15;
  localparam logic [9:0] WIPER_MID    = 10'h200;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int         CLK_HZ       = 20_000_000;
  localparam int         STORE_MS     = 6;
  localparam int         STORE_CYCLES = (CLK_HZ / 1000) * STORE_MS;

endpackage : dpc_pkg

// ---- src/dpc_mem.sv ----
// Twenty-entry one-time wiper memory with registered read data.
// Assumes one write per store; written entries are never rewritten.
`timescale 1ns/100ps
module dpc_mem
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Write port
  input  wire logic       wr_en,
  input  wire logic [4:0] wr_addr,
  input  wire logic [9:0] wr_data,
  // Read port
  input  wire logic [4:0] rd_addr,
  output logic      [9:0] rd_data
);
  import dpc_pkg::*;

  logic [9:0] mem_reg [MEM_ENTRIES];

  // Storage array; out-of-range writes are dropped
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < MEM_ENTRIES; i++)
        mem_reg[i] <= 10'h000;
    end
    else if (wr_en && (int'(wr_addr) < MEM_ENTRIES))
    begin
      mem_reg[wr_addr] <= wr_data;
    end
  end

  // Registered read; unmapped addresses read zero
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      rd_data <= 10'h000;
    else if (int'(rd_addr) < MEM_ENTRIES)
      rd_data <= mem_reg[rd_addr];
    else
      rd_data <= 10'h000;
  end

endmodule : dpc_mem

// ---- src/dpc_top.sv ----
// Command and control logic of a single-channel digital potentiometer.
// Assumes a host drives frame select, serial clock and serial data; the
// serial clock is a separate domain and may stop between frames.
`timescale 1ns/100ps
module dpc_top
(
  // Core clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Serial link from the host
  input  wire logic        ser_clk,
  input  wire logic        frame_sel_n,
  input  wire logic        ser_din,
  output logic             ser_dout,
  // Hardware reset pin, active low
  input  wire logic        hw_reset_n,
  // Status and analogue controls
  output logic             ready,
  output logic       [9:0] wiper_pos,
  output logic             term_a_open,
  output logic             wiper_to_b,
  output logic             precision_mode,
  output logic       [3:0] ctrl_bits
);
  import dpc_pkg::*;

  // ---------------------------------------------------------------------------
  // Link domain: shift in, shift out, bit count
  // ---------------------------------------------------------------------------
  logic [15:0] sh_in_reg;
  logic [15:0] sh_out_reg;
  logic [3:0]  bit_cnt_reg;
  logic        whole_reg;
  logic [15:0] cap_word_reg;
  logic        cap_whole_reg;
  logic        cap_tog_reg;
  logic        first_bit_reg;   // high until the first bit of a frame is in
  logic [15:0] out_word_lnk;    // quasi-static word from core domain
  logic [15:0] shifted_in;

  assign shifted_in = {sh_in_reg[14:0], ser_din};

  // Frame start flag, raised asynchronously while frame select is high.
  // The link clock may stand still between frames and could not see the
  // gap itself; a cut frame thus never skews the count of the next one.
  always_ff @(posedge ser_clk or negedge rst_n or posedge frame_sel_n)
  begin
    if (!rst_n)
      first_bit_reg <= 1'b1;
    else if (frame_sel_n)
      first_bit_reg <= 1'b1;
    else
      first_bit_reg <= 1'b0;
  end

  // Bits arrive MSB first on the rising edge; count modulo sixteen
  always_ff @(posedge ser_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sh_in_reg   <= 16'h0000;
      bit_cnt_reg <= 4'h0;
      whole_reg   <= 1'b0;
    end
    else if (!frame_sel_n)
    begin
      sh_in_reg   <= shifted_in;
      bit_cnt_reg <= (first_bit_reg ? 4'h0 : bit_cnt_reg) + 4'h1;
      whole_reg   <= !first_bit_reg && (bit_cnt_reg == 4'hF);
    end
  end

  // Output shifter loads the staged word at the first edge of each frame;
  // that edge shows the word MSB, later edges shift left.
  always_ff @(posedge ser_clk or negedge rst_n)
  begin
    if (!rst_n)
      sh_out_reg <= 16'h0000;
    else if (first_bit_reg && !frame_sel_n)
      sh_out_reg <= {out_word_lnk[14:0], 1'b0};
    else if (!frame_sel_n)
      sh_out_reg <= {sh_out_reg[14:0], 1'b0};
  end

  // Frame end: capture the word on the rising frame-select edge itself,
  // since the serial clock may have stopped by then.
  always_ff @(posedge frame_sel_n or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cap_word_reg  <= 16'h0000;
      cap_whole_reg <= 1'b0;
      cap_tog_reg   <= 1'b0;
    end
    else
    begin
      cap_word_reg  <= sh_in_reg;
      cap_whole_reg <= whole_reg && (bit_cnt_reg == 4'h0);
      cap_tog_reg   <= ~cap_tog_reg;
    end
  end

  // First edge of a frame shows the staged MSB, later edges the shifter
  always_ff @(posedge ser_clk or negedge rst_n)
  begin
    if (!rst_n)
      ser_dout <= 1'b0;
    else if (first_bit_reg && !frame_sel_n)
      ser_dout <= out_word_lnk[15];
    else
      ser_dout <= sh_out_reg[15];
  end

  // ---------------------------------------------------------------------------
  // Crossing into the core domain
  // ---------------------------------------------------------------------------
  logic tog_s1_reg;
  logic tog_s2_reg;
  logic tog_s3_reg;
  logic rst_s1_reg;
  logic rst_s2_reg;
  logic rst_s3_reg;
  logic frame_evt;
  logic hw_rise;

  // Toggle handshake for frame end; two stages before the edge detector
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tog_s1_reg <= 1'b0;
      tog_s2_reg <= 1'b0;
      tog_s3_reg <= 1'b0;
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= 1'b1;
      rst_s3_reg <= 1'b1;
    end
    else
    begin
      tog_s1_reg <= cap_tog_reg;
      tog_s2_reg <= tog_s1_reg;
      tog_s3_reg <= tog_s2_reg;
      rst_s1_reg <= hw_reset_n;
      rst_s2_reg <= rst_s1_reg;
      rst_s3_reg <= rst_s2_reg;
    end
  end

  // Captured word is stable for many core cycles once the toggle arrives
  assign frame_evt = tog_s2_reg ^ tog_s3_reg;
  assign hw_rise   = rst_s2_reg && !rst_s3_reg;

  // ---------------------------------------------------------------------------
  // Core state
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0]
  {
    DPC_IDLE  = 3'b001,
    DPC_LOAD  = 3'b010,
    DPC_STORE = 3'b100
  } dpc_state_t;

  dpc_state_t  state_reg;
  logic [3:0]  ctrl_reg;
  logic [9:0]  wiper_reg;
  logic        shut_reg;
  logic [4:0]  used_reg;        // entries programmed so far
  logic [9:0]  last_val_reg;    // latest stored value, or midscale
  logic [22:0] store_cnt_reg;
  logic [15:0] out_word_reg;
  logic [1:0]  rd_sel_reg;      // 0 echo, 1 wiper, 2 memory, 3 control
  logic [15:0] prev_word_reg;
  logic        mem_wr;
  logic [4:0]  mem_rd_addr_reg;
  logic [9:0]  mem_rd_data;
  logic [3:0]  cmd;
  logic [9:0]  dat;
  logic        exec;
  logic [19:0] therm;
  logic [9:0]  rd_value;

  assign cmd  = cap_word_reg[CMD_MSB:CMD_LSB];
  assign dat  = cap_word_reg[DATA_BITS-1:0];
  // Store in progress locks out whole frames
  assign exec = frame_evt && cap_whole_reg && (state_reg == DPC_IDLE);

  // Thermometer fill: bit i set once entry i has been programmed
  always_comb
  begin
    therm = 20'h00000;
    for (int i = 0; i < MEM_ENTRIES; i++)
      therm[i] = (int'(used_reg) > i);
  end

  // Store sequencer: load, then hold busy for the programming time
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg     <= DPC_IDLE;
      store_cnt_reg <= 23'h000000;
    end
    else
    begin
      case (state_reg)
        DPC_IDLE:
        begin
          if (exec && cmd == CMD_STORE && ctrl_reg[CTL_PROG_EN]
              && int'(used_reg) < MEM_ENTRIES)
            state_reg <= DPC_LOAD;
        end
        DPC_LOAD:
        begin
          store_cnt_reg <= 23'(STORE_CYCLES - 1);
          state_reg     <= DPC_STORE;
        end
        DPC_STORE:
        begin
          if (store_cnt_reg == 23'h000000)
            state_reg <= DPC_IDLE;
          else
            store_cnt_reg <= store_cnt_reg - 23'h000001;
        end
        default:
          state_reg <= DPC_IDLE;
      endcase
    end
  end

  assign mem_wr = (state_reg == DPC_LOAD);

  // Fill count and latest stored value
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      used_reg     <= 5'h00;
      last_val_reg <= WIPER_MID;
    end
    else if (mem_wr)
    begin
      used_reg     <= used_reg + 5'h01;
      last_val_reg <= wiper_reg;
    end
  end

  // Control register; the success bit is hardware owned
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_reg <= CTL_RESET;
    else if (hw_rise)
    begin
      ctrl_reg              <= CTL_RESET;
      ctrl_reg[CTL_PROG_OK] <= mem_wr;                // A landing store still reports
    end
    else if (mem_wr)
      ctrl_reg[CTL_PROG_OK] <= 1'b1;
    else if (exec && cmd == CMD_WR_CTRL)
      ctrl_reg[2:0] <= dat[2:0];
    else if (exec && cmd == CMD_STORE)
      ctrl_reg[CTL_PROG_OK] <= 1'b0;
  end

  // Wiper setting register; locked writes are dropped
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      wiper_reg <= WIPER_MID;
    else if (hw_rise || (exec && cmd == CMD_REFRESH))
      wiper_reg <= last_val_reg;
    else if (exec && cmd == CMD_WR_WIPER && ctrl_reg[CTL_UNLOCK])
      wiper_reg <= dat;
  end

  // Shutdown flag leaves the wiper setting alone
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      shut_reg <= 1'b0;
    else if (exec && cmd == CMD_SHUTDOWN)
      shut_reg <= dat[0];
  end

  // Readback selection for the next frame
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_sel_reg      <= 2'h0;
      prev_word_reg   <= 16'h0000;
      mem_rd_addr_reg <= 5'h00;
    end
    else if (exec)
    begin
      prev_word_reg <= cap_word_reg;
      if (cmd == CMD_RD_WIPER)
        rd_sel_reg <= 2'h1;
      else if (cmd == CMD_RD_MEM)
      begin
        rd_sel_reg      <= 2'h2;
        mem_rd_addr_reg <= dat[ADDR_BITS-1:0];
      end
      else if (cmd == CMD_RD_CTRL)
        rd_sel_reg <= 2'h3;
      else
        rd_sel_reg <= 2'h0;
    end
  end

  // Memory read value with the two status words mapped above the entries
  always_comb
  begin
    if (mem_rd_addr_reg == ADDR_FILL_LO)
      rd_value = therm[9:0];
    else if (mem_rd_addr_reg == ADDR_FILL_HI)
      rd_value = therm[19:10];
    else
      rd_value = mem_rd_data;
  end

  // Word staged for the next frame; held steady between frames so the
  // link domain may sample it as a quasi-static bus
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      out_word_reg <= 16'h0000;
    else if (state_reg == DPC_IDLE)
    begin
      case (rd_sel_reg)
        2'h1:    out_word_reg <= {6'h00, wiper_reg};
        2'h2:    out_word_reg <= {6'h00, rd_value};
        2'h3:    out_word_reg <= {12'h000, ctrl_reg};
        default: out_word_reg <= prev_word_reg;
      endcase
    end
  end

  assign out_word_lnk = out_word_reg;

  // Status and analogue outputs, all registered
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ready          <= 1'b1;
      wiper_pos      <= WIPER_MID;
      term_a_open    <= 1'b0;
      wiper_to_b     <= 1'b0;
      precision_mode <= 1'b1;
      ctrl_bits      <= CTL_RESET;
    end
    else
    begin
      ready          <= (state_reg == DPC_IDLE) && !frame_evt;
      wiper_pos      <= wiper_reg;
      term_a_open    <= shut_reg;
      wiper_to_b     <= shut_reg;
      precision_mode <= !ctrl_reg[CTL_CAL_SEL];
      ctrl_bits      <= ctrl_reg;
    end
  end

  // ---------------------------------------------------------------------------
  // Stored wiper values
  // ---------------------------------------------------------------------------
  dpc_mem u_mem
  (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .wr_en    (mem_wr),
    .wr_addr  (used_reg),
    .wr_data  (wiper_reg),
    .rd_addr  (mem_rd_addr_reg),
    .rd_data  (mem_rd_data)
  );

endmodule : dpc_top

// ---- testbench/dpc_top_chk.sv ----
// Checker for the digipot command block: timing relations at its ports.
// Assumes it is bound to dpc_top and sees only that module's ports.
`timescale 1ns/100ps
module dpc_top_chk
(
  // Core clock and reset
  input wire logic       core_clk,
  input wire logic       rst_n,
  // Host side
  input wire logic       frame_sel_n,
  input wire logic       hw_reset_n,
  // Watched outputs
  input wire logic       ready,
  input wire logic [9:0] wiper_pos,
  input wire logic       term_a_open,
  input wire logic       wiper_to_b,
  input wire logic       precision_mode,
  input wire logic [3:0] ctrl_bits
);
  // ---------------------------------------------------------------------------
  // Event age
  // ---------------------------------------------------------------------------
  logic [3:0] evt_age_reg;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // Cycles since a frame end or reset-pin release; saturates so it never wraps
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      evt_age_reg <= 4'hF;
    else if ($rose(frame_sel_n) || $rose(hw_reset_n))
      evt_age_reg <= 4'h0;
    else if (evt_age_reg != 4'hF)
      evt_age_reg <= evt_age_reg + 4'h1;
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  a_shutdown_pair: assert property (term_a_open == wiper_to_b)
    else $error("terminal controls disagree");
  a_precision_follow: assert property
    (!$stable(ctrl_bits[2]) |-> ##[0:3] (precision_mode == !ctrl_bits[2]))
    else $error("precision mode does not follow control bit 2");
  a_wiper_after_evt: assert property ($changed(wiper_pos) |-> evt_age_reg < 4'hC)
    else $error("wiper moved without a command");
  a_ctrl_after_evt: assert property ($changed(ctrl_bits[2:0]) |-> evt_age_reg < 4'hC)
    else $error("control bits moved without a command");
  a_busy_after_frame: assert property ($fell(ready) |-> evt_age_reg < 4'hC)
    else $error("ready fell without a frame");
  a_store_wiper_hold: assert property ((!ready) [*3] |-> $stable(wiper_pos))
    else $error("wiper changed during store");
  a_store_ctrl_hold: assert property ((!ready) [*3] |-> $stable(ctrl_bits[2:0]))
    else $error("control changed during store");
  a_shut_wiper_keep: assert property ($rose(term_a_open) |-> $stable(wiper_pos))
    else $error("shutdown altered the wiper");
  a_hwreset_ctrl: assert property ($rose(hw_reset_n) |-> ##[1:8] (ctrl_bits == 4'h0))
    else $error("reset pin did not clear control");

  c_store: cover property ($fell(ready) ##3 !ready);
  c_shutdown: cover property ($rose(term_a_open));
  c_hw_reset: cover property ($rose(hw_reset_n));
endmodule : dpc_top_chk

bind dpc_top dpc_top_chk u_dpc_top_chk
(
  .core_clk       (core_clk),
  .rst_n          (rst_n),
  .frame_sel_n    (frame_sel_n),
  .hw_reset_n     (hw_reset_n),
  .ready          (ready),
  .wiper_pos      (wiper_pos),
  .term_a_open    (term_a_open),
  .wiper_to_b     (wiper_to_b),
  .precision_mode (precision_mode),
  .ctrl_bits      (ctrl_bits)
);

// ---- testbench/dpc_host_model.sv ----
// Serial host model: frame select, 12 ns link clock and data, MSB first.
// Assumes the bench calls its tasks; the link clock stands still between frames.
`timescale 1ns/100ps
module dpc_host_model
(
  // Link outputs
  output logic      ser_clk,
  output logic      frame_sel_n,
  output logic      ser_din,
  // Link input
  input  wire logic ser_dout
);
  // Idle link
  initial
  begin
    ser_clk = 1'b0;
    frame_sel_n = 1'b1;
    ser_din = 1'b0;
  end

  // Lone link clock pulse outside a frame, lets the link domain see reset
  task automatic tick;
    #6 ser_clk = 1'b1;
    #6 ser_clk = 1'b0;
  endtask : tick

  // One frame of nbits taken from the top of word; slow stretches the low phase
  task automatic xfer(input logic [15:0] word, input int nbits, input bit slow,
                      output logic [15:0] rx);
    int i;
    rx = 16'h0000;
    frame_sel_n = 1'b0;
    for (i = 0; i < nbits; i++)
    begin
      ser_din = word[15 - i];
      #(slow ? 30 : 6);
      ser_clk = 1'b1;
      #6;
      ser_clk = 1'b0;
      rx = {rx[14:0], ser_dout};
    end
    #6;
    frame_sel_n = 1'b1;
    // Released line must not look like held data
    ser_din = ~ser_din;
  endtask : xfer
endmodule : dpc_host_model

// ---- testbench/dpc_top_tb.sv ----
// Self-checking bench for the digipot command block.
// Assumes the host model drives the link and one store takes about 6 ms.
`timescale 1ns/100ps
module dpc_top_tb;
  import dpc_pkg::*;
  logic        core_clk, rst_n, hw_reset_n, ser_clk, frame_sel_n, ser_din, ser_dout;
  logic        ready, term_a_open, wiper_to_b, precision_mode;
  logic [9:0]  wiper_pos;
  logic [3:0]  ctrl_bits;
  logic [15:0] rx, fill_lo;
  int          mismatches, total_checks;

  // Core clock, 50 ns
  always #25 core_clk = ~core_clk;

  dpc_top u_dpc_top (.core_clk(core_clk), .rst_n(rst_n), .ser_clk(ser_clk),
    .frame_sel_n(frame_sel_n), .ser_din(ser_din), .ser_dout(ser_dout),
    .hw_reset_n(hw_reset_n), .ready(ready), .wiper_pos(wiper_pos),
    .term_a_open(term_a_open), .wiper_to_b(wiper_to_b),
    .precision_mode(precision_mode), .ctrl_bits(ctrl_bits));
  dpc_host_model u_dpc_host_model (.ser_clk(ser_clk), .frame_sel_n(frame_sel_n),
    .ser_din(ser_din), .ser_dout(ser_dout));

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test;
    if (mismatches == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test

  // Frame, then ten core cycles so the staged word and outputs settle
  task automatic frame(input logic [15:0] w, input int n = 16, input bit slow = 1'b0);
    @(posedge core_clk);
    #1;
    u_dpc_host_model.xfer(w, n, slow, rx);
    repeat (10) @(posedge core_clk);
    #1;
  endtask : frame

  // Bounded wait for store completion
  task automatic wait_ready;
    int k;
    for (k = 0; k < 130000 && ready !== 1'b1; k++)
      @(posedge core_clk);
    #1;
  endtask : wait_ready

  // Watchdog: 7 ms, one 6 ms store plus some twenty-two short frames
  initial
  begin
    #7_000_000;
    mismatches++;
    end_of_test();
  end

  // ---------------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    hw_reset_n = 1'b1;
    u_dpc_host_model.tick();
    repeat (5) @(posedge core_clk);
    #1 rst_n = 1'b1;
    u_dpc_host_model.tick();
    check(16'(wiper_pos), 16'(WIPER_MID));
    check(16'(ctrl_bits), 16'(CTL_RESET));
    check(16'(precision_mode), 16'h0001);
    frame(16'h0500);
    check(16'(wiper_pos), 16'(WIPER_MID));
    frame(16'h0C00);
    check(rx, 16'h0500);
    check(16'({ready, ctrl_bits}), 16'h0010);
    frame(16'h1803);
    check(16'(ctrl_bits), 16'h0003);
    frame(16'h0500);
    check(rx, 16'h1803);
    check(16'(wiper_pos), 16'h0100);
    frame(16'h0800);
    frame(16'h0C00);
    check(rx, 16'h0100);
    check(16'(ready), 16'h0000);
    frame(16'h0504);
    check(16'(wiper_pos), 16'h0100);
    wait_ready();
    check(16'(ready), 16'h0001);
    frame(16'h1C00);
    frame(16'h0000);
    check(rx, 16'h000B);
    frame(16'h1400);
    frame(16'h1414);
    check(rx, 16'h0100);
    frame(16'h1415);
    fill_lo = rx;
    check(rx, 16'h0001);
    frame(16'h0000);
    check(rx, 16'h0000);
    check(16'($countones(fill_lo) + $countones(rx) - 1), 16'h0000);
    frame(16'h0508, 15);
    check(16'(wiper_pos), 16'h0100);
    frame(16'h2001);
    check(16'({term_a_open, wiper_to_b, wiper_pos}), 16'h0D00);
    frame(16'h0508, 16, 1'b1);
    check(16'(wiper_pos), 16'h0108);
    frame(16'h2000);
    check(16'({term_a_open, wiper_to_b}), 16'h0000);
    frame(16'h1807);
    check(16'({precision_mode, ctrl_bits[2:0]}), 16'h0007);
    hw_reset_n = 1'b0;
    repeat (5) @(posedge core_clk);
    #1 hw_reset_n = 1'b1;
    repeat (10) @(posedge core_clk);
    #1;
    check(16'({ctrl_bits, wiper_pos}), 16'h0100);
    frame(16'h0520);
    check(16'(wiper_pos), 16'h0100);
    frame(16'h1802);
    frame(16'h0450);
    check(16'(wiper_pos), 16'h0050);
    frame(16'h1000);
    check(16'(wiper_pos), 16'h0100);
    end_of_test();
  end
endmodule : dpc_top_tb
